// >>> core/adc_scan_pkg.sv
package adc_scan_pkg;
	localparam int unsigned NUM_CH = 16;
	localparam int unsigned RES_W = 10;
	localparam int unsigned CLK_MHZ = 250;
	localparam int unsigned TICK_US = 40;
	localparam int unsigned TICK_CYCLES = TICK_US * CLK_MHZ;
	localparam logic [7:0] OFF_CONTROL = 8'h00;
	localparam logic [7:0] OFF_DELAY = 8'h04;
	localparam logic [7:0] OFF_STATUS = 8'h08;
	localparam logic [7:0] OFF_SINGLE = 8'h0C;
	localparam logic [7:0] OFF_REPEAT = 8'h10;
	localparam logic [7:0] OFF_RESULT0 = 8'h14;
	localparam logic [7:0] OFF_RESULT15 = 8'h50;
	localparam logic [7:0] OFF_IRQ_MASK = 8'h60;
	localparam int unsigned CTL_ENABLE = 0;
	localparam int unsigned CTL_SINGLE = 1;
	localparam int unsigned CTL_REPEAT = 2;
	localparam int unsigned CTL_RPT_DONE = 6;
	localparam int unsigned CTL_SGL_DONE = 7;
	localparam int unsigned IRQ_RPT = 0;
	localparam int unsigned IRQ_SGL = 1;
	localparam int unsigned DLY_START_LSB = 0;
	localparam int unsigned DLY_RPT_LSB = 16;
	localparam logic [31:0] RST_WORD = 32'h0000_0000;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

	typedef struct packed {
		logic req;
		logic [3:0] chan;
	} conv_req_t;

	typedef struct packed {
		logic done;
		logic [RES_W-1:0] data;
	} conv_rsp_t;
endpackage

// >>> core/adc_result_mem.sv
`timescale 1ns/10ps
`default_nettype none
module adc_result_mem #(
	parameter int DEPTH = 16,
	parameter int WIDTH = 10
) (
	input wire logic core_clk_i,
	input wire logic wr_en_i,
	input wire logic [$clog2(DEPTH)-1:0] wr_addr_i,
	input wire logic [WIDTH-1:0] wr_data_i,
	input wire logic [$clog2(DEPTH)-1:0] rd_addr_i,
	output logic [WIDTH-1:0] rd_data_o
);
	// no reset on the array; read data is registered for a coherent word
	logic [WIDTH-1:0] mem [DEPTH];

	always_ff @(posedge core_clk_i) begin
		if (wr_en_i) begin
			mem[wr_addr_i] <= wr_data_i;
		end
		rd_data_o <= mem[rd_addr_i];
	end
endmodule
`default_nettype wire

// >>> core/adc_scan_sequencer.sv
// The AHB-Lite interface to the registers was decided locally.
`timescale 1ns/10ps
`default_nettype none
module adc_scan_sequencer
	import adc_scan_pkg::*;
#(
	parameter int unsigned TICK_DIV = TICK_CYCLES
) (
	input wire logic core_clk_i,
	input wire logic rst_b_i,
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic [31:0] hrdata_o,
	output logic hreadyout_o,
	output logic hresp_o,
	output adc_scan_pkg::conv_req_t conv_req_o,
	input wire adc_scan_pkg::conv_rsp_t conv_rsp_i,
	output logic irq_o
);
	import adc_scan_pkg::*;

	typedef enum logic [3:0] {
		S_IDLE = 4'b0001,
		S_PICK = 4'b0010,
		S_CONV = 4'b0100,
		S_WAIT = 4'b1000
	} seq_state_t;

	function automatic logic [4:0] lowest_set(input logic [15:0] m);
		lowest_set = 5'h10;
		for (int i = 15; i >= 0; i--) begin
			if (m[i]) begin
				lowest_set = 5'(i);
			end
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// bus slave
	logic [7:0] a_addr_reg;
	logic a_wr_reg, a_rd_reg, rd_pend_reg;
	logic [31:0] rdata_reg;
	logic [31:0] delay_reg, single_mask_reg, repeat_mask_reg;
	logic [15:0] done_reg, done_next;
	logic en_reg, start_single_reg, start_repeat_reg, sgl_done_reg, rpt_done_reg;
	logic [1:0] irq_mask_reg;
	logic [RES_W-1:0] mem_rd;
	logic [3:0] scan_ch_reg;

	wire take = hsel_i && hready_i && htrans_i[1];
	wire wr_now = a_wr_reg;
	wire [31:0] wd = hwdata_i;
	wire wr_ctl = wr_now && a_addr_reg == OFF_CONTROL;
	wire wr_dly = wr_now && a_addr_reg == OFF_DELAY;
	wire wr_sts = wr_now && a_addr_reg == OFF_STATUS;
	wire wr_sgl = wr_now && a_addr_reg == OFF_SINGLE;
	wire wr_rpt = wr_now && a_addr_reg == OFF_REPEAT;
	wire wr_msk = wr_now && a_addr_reg == OFF_IRQ_MASK;
	wire is_res = a_addr_reg >= OFF_RESULT0 && a_addr_reg <= OFF_RESULT15;
	wire [7:0] res_off = a_addr_reg - OFF_RESULT0;
	wire [3:0] res_idx = res_off[5:2];
	wire [31:0] ctl_word = {24'h0, sgl_done_reg, rpt_done_reg, 3'h0, start_repeat_reg,
		start_single_reg, en_reg};
	wire [31:0] rd_mux = a_addr_reg == OFF_CONTROL ? ctl_word :
		a_addr_reg == OFF_DELAY ? delay_reg :
		a_addr_reg == OFF_STATUS ? {16'h0, done_reg} :
		a_addr_reg == OFF_SINGLE ? single_mask_reg :
		a_addr_reg == OFF_REPEAT ? repeat_mask_reg :
		a_addr_reg == OFF_IRQ_MASK ? {30'h0, irq_mask_reg} :
		is_res ? {22'h0, mem_rd} : 32'h0000_0000;

	// reads take one wait cycle so the result memory can answer
	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			a_addr_reg <= 8'h00;
			a_wr_reg <= 1'b0;
			a_rd_reg <= 1'b0;
			rd_pend_reg <= 1'b0;
			hreadyout_o <= 1'b1;
			hrdata_o <= RST_WORD;
			hresp_o <= 1'b0;
		end else begin
			hresp_o <= 1'b0;
			if (take) begin
				a_addr_reg <= haddr_i[7:0];
			end
			a_wr_reg <= take && hwrite_i;
			a_rd_reg <= take && !hwrite_i;
			hreadyout_o <= !(take && !hwrite_i);
			rd_pend_reg <= a_rd_reg;
			if (a_rd_reg) begin
				hrdata_o <= rd_mux;
			end
		end
	end

	// the read index comes from the address phase so the word is ready in the data phase
	wire [7:0] take_off = haddr_i[7:0] - OFF_RESULT0;
	adc_result_mem #(.DEPTH(NUM_CH), .WIDTH(RES_W)) u_mem (
		.core_clk_i(core_clk_i),
		.wr_en_i(conv_rsp_i.done && conv_req_o.req),
		.wr_addr_i(scan_ch_reg),
		.wr_data_i(conv_rsp_i.data),
		.rd_addr_i(take ? take_off[5:2] : res_idx),
		.rd_data_o(mem_rd)
	);

	////////////////////////////////////////////////////////////////////////////////
	// tick prescaler and delay timer
	logic [$clog2(TICK_DIV)-1:0] pre_reg;
	logic [15:0] wait_reg;
	logic waiting_reg, rpt_pend_reg, cur_rpt_reg;
	wire tick = pre_reg == ($clog2(TICK_DIV))'(TICK_DIV - 1);

	// held at zero outside waits so every wait counts whole ticks from its load
	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			pre_reg <= '0;
		end else begin
			pre_reg <= (tick || !waiting_reg) ? '0 : pre_reg + 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// scan sequencer
	seq_state_t state_reg;
	logic [15:0] scan_mask_reg;
	wire [4:0] nxt = lowest_set(scan_mask_reg);
	wire rpt_rise = wr_ctl && wd[CTL_REPEAT] && !start_repeat_reg;
	wire begin_scan = state_reg == S_IDLE && en_reg && (start_single_reg || rpt_pend_reg);
	// single wins when both are pending; a pending repeat pass runs right after it
	wire begin_sgl = begin_scan && start_single_reg;
	wire begin_rpt = begin_scan && !start_single_reg;
	wire conv_end = state_reg == S_CONV && conv_rsp_i.done;
	wire scan_end = state_reg == S_PICK && nxt[4];
	wire [15:0] ch_hot = 16'h0001 << scan_ch_reg;

	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state_reg <= S_IDLE;
			scan_mask_reg <= 16'h0000;
			scan_ch_reg <= 4'h0;
			cur_rpt_reg <= 1'b0;
			conv_req_o <= '0;
		end else begin
			case (state_reg)
				S_IDLE: begin
					if (begin_scan) begin
						scan_mask_reg <= begin_sgl ? single_mask_reg[15:0] :
							repeat_mask_reg[15:0];
						cur_rpt_reg <= !begin_sgl;
						state_reg <= S_PICK;
					end
				end
				S_PICK: begin
					if (nxt[4]) begin
						state_reg <= S_IDLE;
					end else begin
						scan_ch_reg <= nxt[3:0];
						scan_mask_reg[nxt[3:0]] <= 1'b0;
						conv_req_o <= '{req: 1'b1, chan: nxt[3:0]};
						state_reg <= S_CONV;
					end
				end
				S_CONV: begin
					if (conv_rsp_i.done) begin
						conv_req_o <= '0;
						state_reg <= S_PICK;
					end
				end
				default: state_reg <= S_IDLE;
			endcase
		end
	end

	// repeat scheduling: start delay, then interval restarted at each pass end
	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			waiting_reg <= 1'b0;
			wait_reg <= 16'h0000;
			rpt_pend_reg <= 1'b0;
		end else begin
			if (rpt_rise) begin
				wait_reg <= delay_reg[DLY_START_LSB +: 16];
				waiting_reg <= 1'b1;
			end else if (scan_end && cur_rpt_reg && start_repeat_reg) begin
				wait_reg <= delay_reg[DLY_RPT_LSB +: 16];
				waiting_reg <= 1'b1;
			end else if (waiting_reg && wait_reg == 16'h0) begin
				waiting_reg <= 1'b0;
				rpt_pend_reg <= start_repeat_reg;
			end else if (waiting_reg && tick) begin
				wait_reg <= wait_reg - 16'h0001;
			end
			if (begin_rpt || !start_repeat_reg) begin
				rpt_pend_reg <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// registers and flags
	// a completion in the clearing cycle wins, so no finished channel goes unseen
	assign done_next = (done_reg & ~(wr_sts ? wd[15:0] : 16'h0)) | (conv_end ? ch_hot : 16'h0);

	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			delay_reg <= RST_WORD;
			single_mask_reg <= RST_WORD;
			repeat_mask_reg <= RST_WORD;
			done_reg <= 16'h0000;
			en_reg <= 1'b0;
			start_single_reg <= 1'b0;
			start_repeat_reg <= 1'b0;
			sgl_done_reg <= 1'b0;
			rpt_done_reg <= 1'b0;
			irq_mask_reg <= 2'h0;
			irq_o <= 1'b0;
		end else begin
			if (wr_dly) delay_reg <= wd;
			if (wr_sgl) single_mask_reg <= {16'h0, wd[15:0]};
			if (wr_rpt) repeat_mask_reg <= {16'h0, wd[15:0]};
			if (wr_msk) irq_mask_reg <= wd[1:0];
			done_reg <= done_next;
			if (wr_ctl) begin
				en_reg <= wd[CTL_ENABLE];
				start_repeat_reg <= wd[CTL_REPEAT];
			end
			if (begin_sgl) begin
				start_single_reg <= 1'b0;
			end else if (wr_ctl && wd[CTL_SINGLE]) begin
				start_single_reg <= 1'b1;
			end
			if (begin_sgl) begin
				sgl_done_reg <= 1'b0;
			end else if (scan_end && !cur_rpt_reg) begin
				sgl_done_reg <= 1'b1;
			end else if (wr_ctl && wd[CTL_SGL_DONE]) begin
				sgl_done_reg <= 1'b0;
			end
			if (begin_rpt) begin
				rpt_done_reg <= 1'b0;
			end else if (scan_end && cur_rpt_reg) begin
				rpt_done_reg <= 1'b1;
			end else if (wr_ctl && wd[CTL_RPT_DONE]) begin
				rpt_done_reg <= 1'b0;
			end
			irq_o <= |({sgl_done_reg, rpt_done_reg} & irq_mask_reg);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// checks
	a_done_sets: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		conv_end |=> done_reg[$past(scan_ch_reg)]) else $error("channel flag not set");
	a_w0_keeps: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		(done_reg != 16'h0 && !wr_sts) |=> (done_reg & $past(done_reg)) == $past(done_reg))
		else $error("flag lost without write");
	a_sgl_clear: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		begin_sgl |=> !start_single_reg) else $error("single start stuck");
	a_scan_done: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		(scan_end && !cur_rpt_reg) |=> sgl_done_reg) else $error("single done missing");
	a_rpt_done: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		(scan_end && cur_rpt_reg) |=> rpt_done_reg) else $error("repeat done missing");
	a_order_up: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		(conv_end ##1 (state_reg == S_PICK && !nxt[4])) |=> scan_ch_reg > $past(scan_ch_reg, 2))
		else $error("channel order broken");
	a_sgl_nodelay: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		(start_single_reg && en_reg && state_reg == S_IDLE) |=> state_reg == S_PICK)
		else $error("single scan delayed");
	a_new_clears: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		begin_rpt |=> !rpt_done_reg) else $error("repeat done not cleared");
	a_res_zero: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		(rd_pend_reg && $past(is_res)) |-> hrdata_o[31:RES_W] == 22'h0)
		else $error("result high bits set");
	c_single: cover property (@(posedge core_clk_i) begin_sgl);
	c_repeat: cover property (@(posedge core_clk_i) begin_rpt);
	c_back: cover property (@(posedge core_clk_i) scan_end && start_single_reg);
	c_irq: cover property (@(posedge core_clk_i) irq_o);
endmodule
`default_nettype wire

// >>> bench/conv_model.sv
`timescale 1ns/10ps
`default_nettype none
module conv_model
	import adc_scan_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic rst_b_i,
	input wire logic slow_i,
	input wire adc_scan_pkg::conv_req_t conv_req_i,
	output adc_scan_pkg::conv_rsp_t conv_rsp_o,
	output var int count_o
);
	import adc_scan_pkg::*;
	logic [1:0] st_reg;
	logic [3:0] wait_reg;
	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			st_reg <= 2'h0;
			wait_reg <= 4'h0;
			conv_rsp_o <= '0;
			count_o <= 0;
		end else begin
			case (st_reg)
				2'h0: if (conv_req_i.req) begin
					wait_reg <= slow_i ? {2'h1, conv_req_i.chan[1:0]} : 4'h0;
					st_reg <= 2'h1;
				end
				2'h1: if (wait_reg == 4'h0) begin
					conv_rsp_o <= {1'b1, conv_req_i.chan, conv_req_i.chan, 2'b01};
					count_o <= count_o + 1;
					st_reg <= 2'h2;
				end else begin
					wait_reg <= wait_reg - 4'h1;
				end
				// released data shows the inverse so a stale sample cannot pass
				2'h2: begin
					conv_rsp_o <= {1'b0, ~conv_rsp_o.data};
					st_reg <= 2'h3;
				end
				default: if (!conv_req_i.req) begin
					st_reg <= 2'h0;
				end
			endcase
		end
	end
endmodule
`default_nettype wire

// >>> bench/test_adc_scan_sequencer.sv
`timescale 1ns/10ps
`default_nettype none
module test_adc_scan_sequencer;
	import adc_scan_pkg::*;
	localparam int unsigned TICK = 4;
	logic core_clk, rst_b, hsel, hwrite, slow, hreadyout, hresp, irq;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0] htrans;
	logic [2:0] hsize;
	conv_req_t conv_req;
	conv_rsp_t conv_rsp;
	logic [31:0] rd_q[$];
	logic [3:0] ch_q[$];
	logic [7:0] offs[7] = '{OFF_CONTROL, OFF_DELAY, OFF_STATUS, OFF_SINGLE, OFF_REPEAT,
		OFF_IRQ_MASK, 8'h58};
	logic rd_dp = 1'b0;
	logic req_d = 1'b0;
	logic [15:0] sm, rm;
	int fails = 0, num_checks = 0, cyc = 0, cnt, ecnt = 0, n, done_cyc = 0, max_gap = 0;
	int seed = 61570;
	adc_scan_sequencer #(.TICK_DIV(TICK)) uut (.core_clk_i(core_clk), .rst_b_i(rst_b),
		.hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize),
		.hwdata_i(hwdata), .hready_i(hreadyout), .hrdata_o(hrdata), .hreadyout_o(hreadyout),
		.hresp_o(hresp), .conv_req_o(conv_req), .conv_rsp_i(conv_rsp), .irq_o(irq));
	conv_model conv (.core_clk_i(core_clk), .rst_b_i(rst_b), .slow_i(slow),
		.conv_req_i(conv_req), .conv_rsp_o(conv_rsp), .count_o(cnt));
	////////////////////////////////////////////////////////////////////////////////
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic finish_test();
		if (fails == 0 && num_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// whole-word transfers only, so result reads stay coherent
	task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
		@(posedge core_clk);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= HTRANS_NONSEQ;
		hwrite <= w;
		do @(posedge core_clk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		rd_dp <= !w;
		do @(posedge core_clk); while (hreadyout !== 1'b1);
		rd_dp <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(a, 1'b1, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		rd_q.push_back(e);
		bus(a, 1'b0, 32'h0000_0000);
	endtask
	task automatic push_mask(input logic [15:0] m);
		for (int i = 0; i < 16; i++) if (m[i]) begin
			ch_q.push_back(4'(i));
			ecnt++;
		end
	endtask
	task automatic wait_cnt();
		for (int i = 0; i < 3000 && cnt < ecnt; i++) @(posedge core_clk);
		repeat (4) @(posedge core_clk);
	endtask
	task automatic wait_req();
		for (n = 0; n < 300 && conv_req.req !== 1'b1; n++) @(posedge core_clk);
	endtask
	task automatic irq_is(input logic v);
		repeat (2) @(posedge core_clk);
		cmp({31'h0, irq}, {31'h0, v});
	endtask
	function automatic logic [31:0] res(input int c);
		return {22'h0, 4'(c), 4'(c), 2'b01};
	endfunction
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			fails++;
			finish_test();
		end
	end
	always @(posedge core_clk) begin
		if (rd_dp && hreadyout === 1'b1) cmp(hrdata, rd_q.pop_front());
		if (conv_rsp.done === 1'b1) done_cyc <= cyc;
		if (conv_req.req === 1'b1 && !req_d && ch_q.size() > 0) begin
			cmp({28'h0, conv_req.chan}, {28'h0, ch_q.pop_front()});
			if (cyc - done_cyc > max_gap) max_gap <= cyc - done_cyc;
		end
		req_d <= conv_req.req;
	end
	initial begin
		rst_b = 1'b0;
		{hsel, haddr, htrans, hwrite, hwdata, slow} = '0;
		hsize = 3'h2;
		repeat (5) @(posedge core_clk);
		rst_b <= 1'b1;
		wr(8'h58, 32'hFFFF_FFFF);
		foreach (offs[i]) rd(offs[i], RST_WORD);
		sm = 16'($random(seed)) | 16'h0001;
		rm = 16'($random(seed)) | 16'h8000;
		wr(OFF_DELAY, 32'h0005_0003);
		rd(OFF_DELAY, 32'h0005_0003);
		wr(OFF_SINGLE, {16'h0, sm});
		wr(OFF_REPEAT, {16'h0, rm});
		rd(OFF_REPEAT, {16'h0, rm});
		wr(OFF_IRQ_MASK, 32'h0000_0002);
		push_mask(sm);
		wr(OFF_CONTROL, 32'h0000_0003);
		wait_req();
		cmp({31'h0, n < 6}, 32'h1);
		wait_cnt();
		cmp({31'h0, irq}, 32'h1);
		rd(OFF_CONTROL, 32'h0000_0081);
		rd(OFF_STATUS, {16'h0, sm});
		for (int i = 0; i < 16; i++) if (sm[i]) rd(OFF_RESULT0 + 8'(4 * i), res(i));
		wr(OFF_STATUS, 32'h0000_0000);
		rd(OFF_STATUS, {16'h0, sm});
		wr(OFF_STATUS, {16'h0, sm});
		rd(OFF_STATUS, 32'h0000_0000);
		wr(OFF_IRQ_MASK, 32'h0000_0000);
		irq_is(1'b0);
		wr(OFF_IRQ_MASK, 32'h0000_0002);
		irq_is(1'b1);
		wr(OFF_CONTROL, 32'h0000_0081);
		irq_is(1'b0);
		// repeat: start delay of 3 ticks, gap of 5 ticks between passes
		slow <= 1'b1;
		push_mask(rm);
		push_mask(rm);
		wr(OFF_CONTROL, 32'h0000_0005);
		wait_req();
		cmp({31'h0, n >= 2 * TICK && n <= 4 * TICK + 4}, 32'h1);
		@(posedge core_clk);
		max_gap = 0;
		wait_cnt();
		wr(OFF_CONTROL, 32'h0000_0001);
		repeat (60) @(posedge core_clk);
		cmp(cnt, ecnt);
		cmp({31'h0, max_gap >= 4 * TICK && max_gap <= 6 * TICK + 4}, 32'h1);
		rd(OFF_CONTROL, 32'h0000_0041);
		// zero delays, single requested in mid-pass of a repeat scan
		wr(OFF_DELAY, 32'h0000_0000);
		push_mask(rm);
		push_mask(sm);
		push_mask(rm);
		wr(OFF_CONTROL, 32'h0000_0005);
		wait_req();
		cmp({31'h0, n < 6}, 32'h1);
		rd(OFF_CONTROL, 32'h0000_0005);
		max_gap = 0;
		wr(OFF_CONTROL, 32'h0000_0007);
		wait_cnt();
		wr(OFF_CONTROL, 32'h0000_0001);
		cmp({31'h0, max_gap <= 6}, 32'h1);
		cmp(ch_q.size(), 0);
		repeat (300) @(posedge core_clk);
		rd(OFF_CONTROL, 32'h0000_00C1);
		wr(OFF_CONTROL, 32'h0000_00C1);
		rd(OFF_CONTROL, 32'h0000_0001);
		cmp({31'h0, hresp}, 32'h0000_0000);
		finish_test();
	end
endmodule
`default_nettype wire
